/* bench/remote_tx.sv */
// Remote serial transmitter with receive-side bit timing
`default_nettype none
module remote_tx #(
    parameter int BIT = 16
) (
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RST_N,
    // Request from the bench
    input  wire logic       SEND,
    input  wire logic [7:0] DATA,
    // Line and receiver timing
    output logic            LINE,
    output logic            TICK,
    output logic            LOAD,
    output logic [7:0]      LDATA,
    output logic            FEND
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] ph;
    logic [3:0] idx;
    logic       busy;
    logic [9:0] frame;
    // Bits change at phase zero; tick sits mid-bit so it never meets a frame end
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ph    <= 5'h00;
            idx   <= 4'h0;
            busy  <= 1'h0;
            frame <= 10'h3FF;
            LINE  <= 1'h1;
            TICK  <= 1'h0;
            LOAD  <= 1'h0;
            LDATA <= 8'h00;
            FEND  <= 1'h0;
        end else begin
            ph   <= (ph == 5'(BIT - 1)) ? 5'h00 : ph + 5'h01;
            TICK <= (ph == 5'(BIT / 2 - 1));
            LOAD <= busy && idx == 4'hA && ph == 5'(BIT / 2 - 1);
            FEND <= 1'h0;
            if (busy && idx == 4'hA && ph == 5'(BIT / 2 - 1)) begin
                LDATA <= frame[8:1];
            end
            if (SEND && !busy) begin
                frame <= {1'h1, DATA, 1'h0};
                busy  <= 1'h1;
                idx   <= 4'h0;
            end else if (busy && ph == 5'(BIT - 1)) begin
                // Line rests at the mark level between frames
                LINE <= (idx == 4'hA) ? 1'h1 : frame[idx];
                idx  <= idx + 4'h1;
                busy <= (idx != 4'hA);
                FEND <= (idx == 4'hA);
            end
        end
    end
endmodule
`default_nettype wire

/* bench/serial_status_flags_test.sv */
// Self-checking bench for the serial status flag logic
`default_nettype none
module serial_status_flags_test
    import serial_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, rd_pend = 1'h0;
    logic        vacant = 1'h1, busy = 1'h0, send = 1'h0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, sdata = 8'h00, rdata, txd, rxd;
    logic        load_p, pre_p, brk_p, ten, breq, pin, tick, ld, fend, irq;
    int          mismatches = 0, samples_checked = 0, seed = 37707;
    logic [15:0] rq[$];
    logic [2:0]  pq[$];
    always #5 clock = ~clock;
    // Device under test and the far-side transmitter
    serial_status_flags uut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .TX_BUFFER_VACANT(vacant), .TX_BUSY(busy), .TX_DATA(txd), .TX_DATA_LOAD(load_p),
        .PREAMBLE_QUEUE(pre_p), .BREAK_QUEUE(brk_p), .TX_ENABLE(ten), .BREAK_REQUEST(breq), .RX_PIN(pin),
        .BIT_TICK(tick), .RX_CHAR_LOAD(ld), .RX_CHAR_DATA(rxd), .RX_FRAME_END(fend), .IRQ(irq));
    remote_tx peer (.CLOCK(clock), .RST_N(rst_n), .SEND(send), .DATA(sdata), .LINE(pin), .TICK(tick),
        .LOAD(ld), .LDATA(rxd), .FEND(fend));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Strobe dropped with a spare cycle, so back-to-back calls never collide
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [2:0] p);
        if (p !== 3'h0) pq.push_back(p);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clock);
        wr <= 1'h0;
        @(posedge clock);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        rq.push_back({m, e});
        addr <= a;
        rd   <= 1'h1;
        @(posedge clock);
        rd <= 1'h0;
        @(posedge clock);
    endtask
    task automatic rs(input logic d, input logic f, input logic i);
        rd_reg(OFS_STATUS, {vacant, d, f, i, 4'h0}, 8'hF0);
    endtask
    task automatic frame(input logic [7:0] d);
        int n;
        sdata <= d;
        send  <= 1'h1;
        @(posedge clock);
        send <= 1'h0;
        n = 0;
        while (fend !== 1'h1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 400) begin
            mismatches++;
            results();
        end
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clock) rd_pend <= rd;
    always @(negedge clock) begin : watch
        logic [15:0] e;
        logic [2:0]  p;
        if (rd_pend && rq.size() > 0) begin
            e = rq.pop_front();
            chk(rdata & e[15:8], e[7:0]);
        end
        if ({load_p, pre_p, brk_p} !== 3'h0) begin
            p = (pq.size() > 0) ? pq.pop_front() : 3'h0;
            chk({5'h0, load_p, pre_p, brk_p}, {5'h0, p});
        end
    end
    initial begin
        #300000;
        mismatches++;
        results();
    end
    initial begin
        logic [7:0] r;
        cyc(16);
        rst_n <= 1'h1;
        cyc(1);
        // Reset values and an unmapped address
        rs(1'h1, 1'h0, 1'h0);
        rd_reg(OFS_CONTROL_2, 8'h00, 8'hFF);
        rd_reg(OFS_INT_MASK, 8'h00, 8'h07);
        rd_reg(8'h18, 8'h00, 8'hFF);
        $display("test reset done");
        // Data write, enable rise, break write, each after a status read
        for (int k = 0; k < 3; k++) begin
            r = 8'($random(seed));
            rs(1'h1, 1'h0, 1'h0);
            wr_reg(k == 0 ? OFS_DATA : OFS_CONTROL_2, k == 0 ? r : (k == 1 ? 8'h08 : 8'h09), 3'h4 >> k);
            if (k == 0) chk(txd, r);
            if (k == 2) chk({6'h0, ten, breq}, 8'h03);
            rs(1'h0, 1'h0, 1'h0);
            busy   <= 1'h1;
            vacant <= 1'h0;
            cyc(3);
            rs(1'h0, 1'h0, 1'h0);
            busy   <= 1'h0;
            vacant <= 1'h1;
            cyc(2);
            rs(1'h1, 1'h0, 1'h0);
        end
        // A data read between does not consume the status read
        wr_reg(OFS_CONTROL_2, 8'h00, 3'h0);
        rd_reg(OFS_DATA, 8'h00, 8'h00);
        wr_reg(OFS_DATA, 8'h5A, 3'h4);
        rs(1'h0, 1'h0, 1'h0);
        busy   <= 1'h1;
        vacant <= 1'h0;
        cyc(2);
        busy   <= 1'h0;
        vacant <= 1'h1;
        cyc(2);
        // Last status read saw done low, so this write must not clear it
        wr_reg(OFS_DATA, 8'hA5, 3'h4);
        rs(1'h1, 1'h0, 1'h0);
        $display("test transmit done");
        // Done event raised, masked and cleared
        rd_reg(OFS_INT_STATUS, 8'h01, 8'h01);
        wr_reg(OFS_INT_MASK, 8'h01, 3'h0);
        chk({7'h0, irq}, 8'h01);
        wr_reg(OFS_INT_MASK, 8'h00, 3'h0);
        chk({7'h0, irq}, 8'h00);
        wr_reg(OFS_INT_MASK, 8'h01, 3'h0);
        wr_reg(OFS_INT_STATUS, 8'h01, 3'h0);
        chk({7'h0, irq}, 8'h00);
        rd_reg(OFS_INT_STATUS, 8'h00, 8'h01);
        $display("test interrupt done");
        // Last data bit low, so the quiet count restarts inside the frame
        r = {1'h0, 7'($random(seed))};
        frame(r);
        rd_reg(OFS_DATA, r, 8'hFF);
        rs(1'h1, 1'h1, 1'h0);
        cyc(120);
        rs(1'h1, 1'h1, 1'h0);
        cyc(30);
        rs(1'h1, 1'h1, 1'h1);
        rd_reg(OFS_DATA, r, 8'hFF);
        rs(1'h1, 1'h0, 1'h0);
        cyc(200);
        rs(1'h1, 1'h0, 1'h0);
        $display("test receive done");
        // All-ones frames under each count start and length choice
        for (int m = 0; m < 3; m++) begin
            wr_reg(OFS_CONTROL_1, m == 0 ? 8'h00 : (m == 1 ? 8'h02 : 8'h03), 3'h0);
            frame(8'hFF);
            cyc(142);
            rs(1'h1, 1'h1, m == 0);
            cyc(14);
            rs(1'h1, 1'h1, m != 2);
            cyc(14);
            rs(1'h1, 1'h1, 1'h1);
            rd_reg(OFS_DATA, 8'hFF, 8'hFF);
            $display("test idle mode %0d done", m);
        end
        cyc(2);
        if (rq.size() != 0 || pq.size() != 0) mismatches++;
        results();
    end
endmodule
`default_nettype wire

/* hdl/rx_line_sync.sv */
// Three-stage synchroniser with agreement filter for the receive pin
`default_nettype none
module rx_line_sync
    import serial_flags_pkg::*;
(
    // Clock and reset
    input  wire logic CLOCK,
    input  wire logic RST_N,
    // Pin and filtered level
    input  wire logic PIN,
    output logic      LEVEL
);
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // Level moves only when the two settled stages agree
    always_comb begin
        next_st       = st;
        next_st.stage = {st.stage[1:0], PIN};
        if (st.stage[1] == st.stage[2]) begin
            next_st.level = st.stage[2];
        end
    end

    // Idle line is high, so reset to high
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st.stage <= RST_SYNC;
            st.level <= RST_RX_LEVEL;
        end else begin
            st <= next_st;
        end
    end

    assign LEVEL = st.level;
endmodule
`default_nettype wire

/* hdl/serial_status_flags.sv */
// Status flags, clear sequences and idle-line detection of the serial port
`default_nettype none
module serial_status_flags
    import serial_flags_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RST_N,
    // Register port
    input  wire logic [7:0]        ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    // Transmitter side
    input  wire logic              TX_BUFFER_VACANT,
    input  wire logic              TX_BUSY,
    output logic      [DATA_W-1:0] TX_DATA,
    output logic                   TX_DATA_LOAD,
    output logic                   PREAMBLE_QUEUE,
    output logic                   BREAK_QUEUE,
    output logic                   TX_ENABLE,
    output logic                   BREAK_REQUEST,
    // Receiver side
    input  wire logic              RX_PIN,
    input  wire logic              BIT_TICK,
    input  wire logic              RX_CHAR_LOAD,
    input  wire logic [DATA_W-1:0] RX_CHAR_DATA,
    input  wire logic              RX_FRAME_END,
    // Interrupt
    output logic                   IRQ
);
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              tx_done;
        logic              rx_full;
        logic              idle;
        logic              seen_tx_done;
        logic              seen_rx_full;
        logic              seen_idle;
        logic              tx_pending;
        logic              long_char;
        logic              quiet_sel;
        logic              tx_enable;
        logic              break_request;
        logic [DATA_W-1:0] tx_data;
        logic              tx_load;
        logic              preamble_q;
        logic              break_q;
        logic [DATA_W-1:0] rx_data;
        logic              idle_armed;
        logic              count_run;
        logic [3:0]        idle_count;
        logic [EV_COUNT-1:0] int_status;
        logic [EV_COUNT-1:0] int_mask;
    } flags_s;

    flags_s st;
    flags_s next_st;

    logic rx_level;

    // Address decode, shared by read and write paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // Pin crosses into the clock domain before anything looks at it
    rx_line_sync u_rx_sync (
        .CLOCK (CLOCK),
        .RST_N (RST_N),
        .PIN   (RX_PIN),
        .LEVEL (rx_level)
    );

    // Decoded accesses
    logic rd_status;
    logic rd_data;
    logic wr_data;
    logic wr_ctrl2;
    logic queue_data;
    logic queue_preamble;
    logic queue_break;
    logic any_queue;
    logic [3:0] idle_limit;
    logic run_ok;
    logic idle_hit;
    logic [EV_COUNT-1:0] events;

    always_comb begin
        rd_status      = RD && hit(ADDR, OFS_STATUS);
        rd_data        = RD && hit(ADDR, OFS_DATA);
        wr_data        = WR && hit(ADDR, OFS_DATA);
        wr_ctrl2       = WR && hit(ADDR, OFS_CONTROL_2);
        queue_data     = wr_data;
        queue_preamble = wr_ctrl2 && !st.tx_enable && WDATA[BIT_TX_ENABLE];
        queue_break    = wr_ctrl2 && WDATA[BIT_BREAK_REQ];
        any_queue      = queue_data || queue_preamble || queue_break;
        idle_limit     = st.long_char ? IDLE_BITS_LONG : IDLE_BITS_SHORT;
        run_ok         = st.count_run || !st.quiet_sel;
        idle_hit       = rx_level && BIT_TICK && run_ok && (st.idle_count == idle_limit - 4'h1);
    end

    // Register port, flags and idle counter in one next-state process
    always_comb begin
        next_st            = st;
        next_st.tx_load    = 1'b0;
        next_st.preamble_q = 1'b0;
        next_st.break_q    = 1'b0;
        next_st.rdata      = '0;
        events             = '0;

        // Reads; data stand only in the following cycle
        if (RD) begin
            unique case (ADDR)
                OFS_STATUS: begin
                    next_st.rdata[BIT_TX_VACANT] = TX_BUFFER_VACANT;
                    next_st.rdata[BIT_TX_DONE]   = st.tx_done;
                    next_st.rdata[BIT_RX_FULL]   = st.rx_full;
                    next_st.rdata[BIT_IDLE]      = st.idle;
                end
                OFS_CONTROL_1: begin
                    next_st.rdata[BIT_LONG_CHAR] = st.long_char;
                    next_st.rdata[BIT_QUIET_SEL] = st.quiet_sel;
                end
                OFS_CONTROL_2: begin
                    next_st.rdata[BIT_TX_ENABLE] = st.tx_enable;
                    next_st.rdata[BIT_BREAK_REQ] = st.break_request;
                end
                OFS_DATA:       next_st.rdata = st.rx_data;
                OFS_INT_STATUS: next_st.rdata[EV_COUNT-1:0] = st.int_status;
                OFS_INT_MASK:   next_st.rdata[EV_COUNT-1:0] = st.int_mask;
                default:        next_st.rdata = '0; // Unmapped reads as zero
            endcase
        end

        // A status read remembers which flags it saw set
        if (rd_status) begin
            next_st.seen_tx_done = st.tx_done;
            next_st.seen_rx_full = st.rx_full;
            next_st.seen_idle    = st.idle;
        end

        // Writes; the status register ignores them
        if (WR && hit(ADDR, OFS_CONTROL_1)) begin
            next_st.long_char = WDATA[BIT_LONG_CHAR];
            next_st.quiet_sel = WDATA[BIT_QUIET_SEL];
        end
        if (wr_ctrl2) begin
            next_st.tx_enable     = WDATA[BIT_TX_ENABLE];
            next_st.break_request = WDATA[BIT_BREAK_REQ];
        end
        if (WR && hit(ADDR, OFS_INT_MASK)) begin
            next_st.int_mask = WDATA[EV_COUNT-1:0];
        end
        if (wr_data) begin
            next_st.tx_data = WDATA;
        end

        // Queue strobes to the transmitter
        next_st.tx_load    = queue_data;
        next_st.preamble_q = queue_preamble;
        next_st.break_q    = queue_break;

        // Pending covers the gap until the shifter reports busy
        if (any_queue) begin
            next_st.tx_pending = 1'b1;
        end else if (TX_BUSY) begin
            next_st.tx_pending = 1'b0;
        end

        // Done flag: activity forces it low, sequence clears it early
        if (TX_BUSY || !TX_BUFFER_VACANT) begin
            next_st.tx_done = 1'b0;
        end else if (any_queue && st.seen_tx_done) begin
            next_st.tx_done = 1'b0;
        end else if (!st.tx_pending && !any_queue) begin
            next_st.tx_done = 1'b1;
        end
        if (any_queue) begin
            next_st.seen_tx_done = 1'b0;
        end

        // Data read ends the receive sequence; a load in the same cycle wins
        if (rd_data) begin
            if (st.seen_rx_full) begin
                next_st.rx_full = 1'b0;
            end
            if (st.seen_idle) begin
                next_st.idle = 1'b0;
            end
            next_st.seen_rx_full = 1'b0;
            next_st.seen_idle    = 1'b0;
        end
        if (RX_CHAR_LOAD) begin
            next_st.rx_full    = 1'b1;
            next_st.rx_data    = RX_CHAR_DATA;
            next_st.idle_armed = 1'b1;
        end

        // Idle counting in bit periods; any low sample restarts it
        if (!rx_level) begin
            next_st.idle_count = 4'h0;
            next_st.count_run  = 1'b0;
        end else if (RX_FRAME_END && st.quiet_sel) begin
            next_st.count_run  = 1'b1;
            next_st.idle_count = 4'h0;
        end else if (BIT_TICK && run_ok && st.idle_count != idle_limit) begin
            next_st.idle_count = st.idle_count + 4'h1;
        end

        // One idle report per period of activity
        if (idle_hit && st.idle_armed) begin
            next_st.idle       = 1'b1;
            next_st.idle_armed = RX_CHAR_LOAD;
        end

        // Sticky interrupt events, write one to clear, set wins
        events[EV_TX_DONE] = next_st.tx_done && !st.tx_done;
        events[EV_RX_FULL] = RX_CHAR_LOAD && !st.rx_full;
        events[EV_IDLE]    = next_st.idle && !st.idle;
        if (WR && hit(ADDR, OFS_INT_STATUS)) begin
            next_st.int_status = st.int_status & ~WDATA[EV_COUNT-1:0];
        end
        next_st.int_status = next_st.int_status | events;
    end

    // State register; only constants under reset
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st          <= '0;
            st.tx_done  <= RST_TX_DONE;
            st.int_mask <= RST_INT_MASK;
        end else begin
            st <= next_st;
        end
    end

    // Outputs, all from flip-flops except the interrupt gate
    assign RDATA          = st.rdata;
    assign TX_DATA        = st.tx_data;
    assign TX_DATA_LOAD   = st.tx_load;
    assign PREAMBLE_QUEUE = st.preamble_q;
    assign BREAK_QUEUE    = st.break_q;
    assign TX_ENABLE      = st.tx_enable;
    assign BREAK_REQUEST  = st.break_request;
    assign IRQ            = |(st.int_status & st.int_mask);

    // Checks on the flag behaviour
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence seq_saw_done;
        rd_status && st.tx_done;
    endsequence

    sequence seq_saw_full;
        rd_status && st.rx_full;
    endsequence

    // Software usually leaves a spare cycle between the two accesses
    sequence seq_quiet_bus;
        !any_queue && !rd_status;
    endsequence

    sequence seq_quiet_ready;
        st.idle_armed && idle_hit;
    endsequence

    a_done_sets_idle: assert property (
        TX_BUFFER_VACANT && !TX_BUSY && !st.tx_pending && !any_queue |=> st.tx_done)
        else $error("done flag did not set with transmitter idle");

    a_done_clear_data: assert property (
        seq_saw_done ##1 seq_quiet_bus ##1 (wr_data && !rd_status) |=> !st.tx_done)
        else $error("data write after status read left done set");

    a_done_clear_preamble: assert property (
        seq_saw_done ##1 seq_quiet_bus ##1 (queue_preamble && !rd_status) |=> !st.tx_done)
        else $error("preamble queue after status read left done set");

    a_done_clear_break: assert property (
        seq_saw_done ##1 seq_quiet_bus ##1 (queue_break && !rd_status) |=> !st.tx_done)
        else $error("break queue after status read left done set");

    a_done_low_busy: assert property (
        TX_BUSY [*2] |-> !st.tx_done)
        else $error("done flag high while transmitting");

    a_full_on_load: assert property (
        RX_CHAR_LOAD |=> st.rx_full && RDATA == '0 || st.rx_full)
        else $error("receive full not set by character load");

    a_full_clear_seq: assert property (
        seq_saw_full ##1 (!rd_data && !rd_status) ##1 (rd_data && !RX_CHAR_LOAD && !rd_status) |=> !st.rx_full)
        else $error("status then data read left receive full set");

    a_full_holds: assert property (
        st.rx_full && !(rd_data && st.seen_rx_full) |=> st.rx_full)
        else $error("receive full cleared without the read sequence");

    a_idle_needs_high: assert property (
        $rose(st.idle) |-> $past(rx_level) && $past(BIT_TICK))
        else $error("idle flag set without a quiet bit period");

    a_count_advance: assert property (
        !st.quiet_sel && rx_level && BIT_TICK && !RX_FRAME_END && st.idle_count < idle_limit
        |=> st.idle_count == $past(st.idle_count) + 4'h1)
        else $error("idle count did not advance on a high bit");

    a_quiet_length: assert property (
        seq_quiet_ready |=> st.idle && $past(st.idle_count) == idle_limit - 4'h1)
        else $error("idle flag not set at the quiet character length");

    a_count_after_stop: assert property (
        st.quiet_sel && !st.count_run && !RX_FRAME_END && rx_level |=> st.idle_count == $past(st.idle_count))
        else $error("idle counted before the stop bits ended");

    a_idle_once: assert property (
        !st.idle_armed && !RX_CHAR_LOAD |=> !$rose(st.idle))
        else $error("idle flag set again without a new character");

    a_low_restarts: assert property (
        !rx_level |=> st.idle_count == 4'h0)
        else $error("low line did not restart the idle count");
endmodule
`default_nettype wire

/* inc/serial_flags_pkg.sv */
// Constants and register map shared by the serial status flag logic
`default_nettype none
package serial_flags_pkg;
    // Register offsets, byte addresses on an 8-bit address port
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_CONTROL_1  = 8'h04;
    localparam logic [7:0] OFS_CONTROL_2  = 8'h08;
    localparam logic [7:0] OFS_DATA       = 8'h0C;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_MASK   = 8'h14;
    // Status field positions
    localparam int BIT_TX_VACANT = 7;
    localparam int BIT_TX_DONE   = 6;
    localparam int BIT_RX_FULL   = 5;
    localparam int BIT_IDLE      = 4;
    // Control one fields
    localparam int BIT_LONG_CHAR = 0;
    localparam int BIT_QUIET_SEL = 1;
    // Control two fields
    localparam int BIT_BREAK_REQ = 0;
    localparam int BIT_TX_ENABLE = 3;
    // Interrupt event positions
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_FULL = 1;
    localparam int EV_IDLE    = 2;
    localparam int EV_COUNT   = 3;
    // Quiet character lengths in bit times
    localparam logic [3:0] IDLE_BITS_SHORT = 4'hA;
    localparam logic [3:0] IDLE_BITS_LONG  = 4'hB;
    // Values after reset
    localparam logic       RST_TX_DONE   = 1'b1;
    localparam logic       RST_RX_LEVEL  = 1'b1;
    localparam logic [2:0] RST_INT_MASK  = 3'h0;
    localparam logic [2:0] RST_SYNC      = 3'h7;
endpackage
`default_nettype wire
